// ==== kdi_entry.sv ====
// Keyboard, sensor and strobed capture with display memory entry, APB slave.
//
// The implementer's own choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
module kdi_entry (
    // APB slave.
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Matrix and strobe side.
    input  wire logic [7:0]  return_lines,
    input  wire logic        shift_input,
    input  wire logic        control_or_strobe_input,
    output logic      [3:0]  scan_line_outputs,
    output logic      [7:0]  display_out,
    output logic             irq
);
    ////////////////////////////////////////////////////////////////////////
    logic [31:0] prdata_reg;
    logic        pready_reg;
    logic        pslverr_reg;
    logic [3:0]  scan_reg;
    logic [7:0]  dout_reg;
    logic        irq_reg;
    logic [9:0]  tick_cnt_reg;
    logic        tick_reg;
    logic [5:0]  sub_reg;
    logic [3:0]  dig_reg;
    logic [1:0]  dd_reg;
    logic [2:0]  kkk_reg;
    logic        ai_reg;
    logic        src_disp_reg;
    logic [3:0]  daddr_reg;
    logic [3:0]  roff_reg;
    logic [2:0]  sptr_reg;
    logic        se_mode_reg;
    logic        err_reg;
    logic [1:0]  win_reg;
    logic        sirq_reg;
    logic        schg_reg;
    logic        busy_reg;
    logic [3:0]  clr_row_reg;
    logic        stb_d_reg;
    logic        ovr_reg;
    logic        und_reg;
    logic [7:0]  fifo_mem [0:7];
    logic [2:0]  wp_reg;
    logic [2:0]  rp_reg;
    logic [3:0]  cnt_reg;
    logic [7:0]  disp_ram [0:15];
    logic [7:0]  sens_ram [0:7];
    logic [2:0]  hist [0:63];

    assign prdata            = prdata_reg;
    assign pready            = pready_reg;
    assign pslverr           = pslverr_reg;
    assign scan_line_outputs = scan_reg;
    assign display_out       = dout_reg;
    assign irq               = irq_reg;

    ////////////////////////////////////////////////////////////////////////
    // Mode decode and bus strobes.
    logic       m_sens;
    logic       m_strb;
    logic       m_nkey;
    logic [3:0] amask;
    logic       setup;
    logic       wr_go;
    logic       rd_go;
    logic       a_data;
    logic       a_cmd;
    logic [7:0] wb;
    logic       cmd_go;
    logic       cf_go;
    logic       cd_go;
    logic       end_go;
    logic       rd_data;
    logic       wr_data;

    assign m_sens  = (kkk_reg[2:1] == 2'h2);
    assign m_strb  = (kkk_reg[2:1] == 2'h3);
    assign m_nkey  = (kkk_reg[2:1] == 2'h1);
    assign amask   = dd_reg[0] ? 4'hf : 4'h7;
    assign setup   = psel & ~penable;
    assign wr_go   = psel & penable & pready_reg & pwrite;
    assign rd_go   = psel & penable & pready_reg & ~pwrite;
    assign a_data  = (paddr == kdi_pkg::ADDR_DATA);
    assign a_cmd   = (paddr == kdi_pkg::ADDR_CMD);
    assign wb      = pwdata[7:0];
    assign cmd_go  = wr_go & a_cmd;
    assign cf_go   = cmd_go & (wb[7:5] == kdi_pkg::OP_CLEAR)
                   & (wb[kdi_pkg::CMD_CF_BIT] | wb[kdi_pkg::CMD_CA_BIT]);
    assign cd_go   = cmd_go & (wb[7:5] == kdi_pkg::OP_CLEAR)
                   & (wb[kdi_pkg::CMD_CD_BIT] | wb[kdi_pkg::CMD_CA_BIT]);
    assign end_go  = cmd_go & (wb[7:5] == kdi_pkg::OP_END_INT);
    assign rd_data = rd_go & a_data;
    assign wr_data = wr_go & a_data;

    ////////////////////////////////////////////////////////////////////////
    // Internal 10 us tick and scan timing; a digit lasts 64 ticks.
    logic key_smp;
    logic row_smp;
    logic scan_end;

    assign key_smp  = tick_reg & (sub_reg[2:0] == 3'h0);
    assign row_smp  = tick_reg & (sub_reg == 6'h00);
    assign scan_end = row_smp & (dig_reg[2:0] == 3'h7);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_cnt_reg <= 10'h000;
            tick_reg     <= 1'b0;
        end else if (tick_cnt_reg == kdi_pkg::TICK_CYC - 10'h001) begin
            tick_cnt_reg <= 10'h000;
            tick_reg     <= 1'b1;
        end else begin
            tick_cnt_reg <= tick_cnt_reg + 10'h001;
            tick_reg     <= 1'b0;
        end
    end

    // Eight digits wrap at 7 so each lit digit gets twice the duty.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sub_reg <= 6'h00;
            dig_reg <= 4'h0;
        end else if (tick_reg) begin
            sub_reg <= sub_reg + 6'h01;
            if (sub_reg == 6'h3f) begin
                dig_reg <= (dig_reg + 4'h1) & amask;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            scan_reg <= 4'h0;
        end else if (kkk_reg[0]) begin
            scan_reg <= 4'h1 << dig_reg[1:0];
        end else begin
            scan_reg <= dig_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Key debounce: three-scan history per key, one column per sample.
    logic [5:0] kidx;
    logic       kdown;
    logic       knew;
    logic       key_ok;
    logic       multi;
    logic [7:0] key_char;

    assign kidx     = {dig_reg[2:0], sub_reg[5:3]};
    assign kdown    = ~return_lines[sub_reg[5:3]];
    assign knew     = key_smp & ~m_sens & ~m_strb & kdown & ~hist[kidx][0];
    assign key_ok   = key_smp & ~m_sens & ~m_strb & kdown
                    & hist[kidx][1] & ~hist[kidx][2];
    assign multi    = knew & (win_reg != 2'h0) & se_mode_reg & m_nkey;
    assign key_char = {control_or_strobe_input, shift_input, kidx};

    generate
        for (genvar k = 0; k < 64; k++) begin : g_hist
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    hist[k] <= 3'h0;
                end else if (key_smp && kidx == 6'(k)) begin
                    hist[k] <= {hist[k][1:0], kdown};
                end
            end
        end
    endgenerate

    // A new press opens a two-scan debounce window.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            win_reg <= 2'h0;
        end else if (knew) begin
            win_reg <= kdi_pkg::DEB_SCANS;
        end else if (scan_end && win_reg != 2'h0) begin
            win_reg <= win_reg - 2'h1;
        end
    end

    // Detection wins over a clear arriving in the same cycle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            err_reg     <= 1'b0;
            se_mode_reg <= 1'b0;
        end else begin
            if (multi) begin
                err_reg <= 1'b1;
            end else if (cf_go) begin
                err_reg <= 1'b0;
            end
            if (end_go && wb[kdi_pkg::CMD_E_BIT]) begin
                se_mode_reg <= 1'b1;
            end else if (cmd_go && wb[7:5] == kdi_pkg::OP_MODE) begin
                se_mode_reg <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Strobe edge, FIFO and its error flags.
    logic       stb_rise;
    logic       push_req;
    logic [7:0] push_dat;
    logic       full;
    logic       push;
    logic       pop;
    logic       rd_fifo;

    assign stb_rise = m_strb & control_or_strobe_input & ~stb_d_reg;
    assign push_req = stb_rise | key_ok;
    assign push_dat = stb_rise ? return_lines : key_char;
    assign full     = (cnt_reg == kdi_pkg::FIFO_DEPTH);
    assign push     = push_req & ~full & ~err_reg & ~cf_go;
    assign rd_fifo  = rd_data & ~src_disp_reg & ~m_sens;
    assign pop      = rd_fifo & (cnt_reg != 4'h0) & ~cf_go;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stb_d_reg <= 1'b0;
        end else begin
            stb_d_reg <= control_or_strobe_input;
        end
    end

    always_ff @(posedge pclk) begin
        if (push) begin
            fifo_mem[wp_reg] <= push_dat;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wp_reg  <= 3'h0;
            rp_reg  <= 3'h0;
            cnt_reg <= 4'h0;
        end else if (cf_go) begin
            wp_reg  <= 3'h0;
            rp_reg  <= 3'h0;
            cnt_reg <= 4'h0;
        end else begin
            wp_reg  <= wp_reg + {2'h0, push};
            rp_reg  <= rp_reg + {2'h0, pop};
            cnt_reg <= cnt_reg + {3'h0, push} - {3'h0, pop};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ovr_reg <= 1'b0;
            und_reg <= 1'b0;
        end else begin
            if (push_req && full && !m_sens) begin
                ovr_reg <= 1'b1;
            end else if (cf_go) begin
                ovr_reg <= 1'b0;
            end
            if (rd_fifo && cnt_reg == 4'h0) begin
                und_reg <= 1'b1;
            end else if (cf_go) begin
                und_reg <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sensor image; writes stop while a change awaits service.
    logic       s_rd;
    logic       s_chg;
    logic [2:0] srow;

    assign srow  = dig_reg[2:0];
    assign s_rd  = rd_data & ~src_disp_reg & m_sens;
    assign s_chg = row_smp & m_sens & ~sirq_reg
                 & (sens_ram[srow] != return_lines);

    always_ff @(posedge pclk) begin
        if (s_chg) begin
            sens_ram[srow] <= return_lines;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            schg_reg <= 1'b0;
            sirq_reg <= 1'b0;
        end else begin
            if (scan_end) begin
                schg_reg <= 1'b0;
            end else if (s_chg) begin
                schg_reg <= 1'b1;
            end
            if (scan_end && (schg_reg || s_chg)) begin
                sirq_reg <= 1'b1;
            end else if (cf_go || (s_rd && !ai_reg) || (end_go && ai_reg)) begin
                sirq_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_reg <= 1'b0;
        end else if (m_sens) begin
            irq_reg <= sirq_reg;
        end else begin
            irq_reg <= (cnt_reg != 4'h0) | err_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Command and address pointers.
    logic dwr;
    logic drd;

    assign dwr = wr_data & ~busy_reg;
    assign drd = rd_data & src_disp_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dd_reg       <= kdi_pkg::DD_RESET;
            kkk_reg      <= kdi_pkg::KKK_RESET;
            ai_reg       <= 1'b0;
            src_disp_reg <= 1'b0;
            daddr_reg    <= 4'h0;
            sptr_reg     <= 3'h0;
        end else if (cmd_go) begin
            case (wb[7:5])
                kdi_pkg::OP_MODE: begin
                    dd_reg  <= wb[4:3];
                    kkk_reg <= wb[2:0];
                end
                kdi_pkg::OP_RD_FIFO: begin
                    src_disp_reg <= 1'b0;
                    ai_reg       <= wb[kdi_pkg::CMD_AI_BIT];
                    sptr_reg     <= wb[2:0];
                end
                kdi_pkg::OP_RD_DISP: begin
                    src_disp_reg <= 1'b1;
                    ai_reg       <= wb[kdi_pkg::CMD_AI_BIT];
                    daddr_reg    <= wb[3:0];
                end
                kdi_pkg::OP_WR_DISP: begin
                    ai_reg    <= wb[kdi_pkg::CMD_AI_BIT];
                    daddr_reg <= wb[3:0];
                end
                kdi_pkg::OP_CLEAR: begin
                    if (cf_go) begin
                        sptr_reg <= 3'h0;
                    end
                end
                default: begin
                end
            endcase
        end else if ((dwr || drd) && ai_reg) begin
            daddr_reg <= (daddr_reg + 4'h1) & amask;
        end else if (s_rd && ai_reg) begin
            sptr_reg <= sptr_reg + 3'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Display memory, clearing engine and right-entry shift offset.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy_reg    <= 1'b0;
            clr_row_reg <= 4'h0;
        end else if (cd_go) begin
            busy_reg    <= 1'b1;
            clr_row_reg <= 4'h0;
        end else if (busy_reg && tick_reg) begin
            clr_row_reg <= clr_row_reg + 4'h1;
            if (clr_row_reg == 4'hf) begin
                busy_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge pclk) begin
        if (busy_reg && tick_reg) begin
            disp_ram[clr_row_reg] <= 8'h00;
        end else if (dwr) begin
            disp_ram[daddr_reg] <= wb;
        end
    end

    // Each right-entry write moves every shown character one place left.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            roff_reg <= 4'h0;
        end else if (cd_go) begin
            roff_reg <= 4'h0;
        end else if (dwr && dd_reg[1]) begin
            roff_reg <= (roff_reg + 4'h1) & amask;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dout_reg <= 8'h00;
        end else if (busy_reg) begin
            dout_reg <= 8'h00;
        end else if (dd_reg[1]) begin
            dout_reg <= disp_ram[(dig_reg + roff_reg) & amask];
        end else begin
            dout_reg <= disp_ram[dig_reg];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // APB answer: one wait-free access phase, read data latched in setup.
    logic [7:0] status;
    logic [7:0] rdat;
    logic       se_bit;

    assign se_bit = m_sens ? sirq_reg : err_reg;
    assign status = {busy_reg, se_bit, ovr_reg, und_reg,
                     full, cnt_reg[2:0]};
    assign rdat   = src_disp_reg ? disp_ram[daddr_reg]
                  : m_sens ? sens_ram[sptr_reg] : fifo_mem[rp_reg];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg  <= 32'h00000000;
        end else begin
            pready_reg  <= setup;
            pslverr_reg <= setup & ~a_data & ~a_cmd;
            if (setup && !pwrite && a_data) begin
                prdata_reg <= {24'h000000, rdat};
            end else if (setup && !pwrite && a_cmd) begin
                prdata_reg <= {24'h000000, status};
            end else if (setup) begin
                prdata_reg <= 32'h00000000;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    sequence s_clear_cmd;
        cd_go;
    endsequence

    sequence s_clear_busy;
        busy_reg [*8];
    endsequence

    AST_ERR_IRQ: assert property (@(posedge pclk) disable iff (!presetn)
        err_reg && !m_sens |=> irq_reg)
        else $error("error flag did not raise irq");
    AST_ERR_BLOCK: assert property (@(posedge pclk) disable iff (!presetn)
        err_reg && !pop |=> cnt_reg <= $past(cnt_reg))
        else $error("fifo grew while error flag set");
    AST_CF_CLR: assert property (@(posedge pclk) disable iff (!presetn)
        cf_go && !(push_req && full && !m_sens) |=>
        cnt_reg == 4'h0 && !ovr_reg && sptr_reg == 3'h0)
        else $error("clear with fifo bit left status");
    AST_ERR_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
        err_reg && !cf_go |=> err_reg)
        else $error("error flag dropped without clear");
    AST_SENS_SET: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(sirq_reg) |-> $past(scan_end))
        else $error("sensor irq rose off scan end");
    AST_SENS_RD: assert property (@(posedge pclk) disable iff (!presetn)
        s_rd && !ai_reg && !scan_end |=> !sirq_reg)
        else $error("sensor irq kept after read");
    AST_OVR: assert property (@(posedge pclk) disable iff (!presetn)
        push_req && full && !m_sens && !pop && !cf_go |=> ovr_reg && cnt_reg == 4'h8)
        else $error("overrun not flagged");
    AST_UND: assert property (@(posedge pclk) disable iff (!presetn)
        rd_fifo && cnt_reg == 4'h0 |=> und_reg)
        else $error("underrun not flagged");
    AST_BUSY: assert property (@(posedge pclk) disable iff (!presetn)
        s_clear_cmd |=> s_clear_busy)
        else $error("display not unavailable during clear");
    AST_AI: assert property (@(posedge pclk) disable iff (!presetn)
        dwr && ai_reg && !cmd_go |=>
        daddr_reg == (($past(daddr_reg) + 4'h1) & amask))
        else $error("write address did not advance");
endmodule
`default_nettype wire

// ==== kdi_pkg.sv ====
// Constants shared by the keyboard, sensor and display entry block.
package kdi_pkg;
    localparam logic [11:0] ADDR_DATA    = 12'h000;
    localparam logic [11:0] ADDR_CMD     = 12'h004;
    localparam int          CLK_NS       = 10;
    localparam int          TICK_NS      = 10000;
    localparam logic [9:0]  TICK_CYC     = 10'(TICK_NS / CLK_NS);
    localparam logic [2:0]  OP_MODE      = 3'h0;
    localparam logic [2:0]  OP_RD_FIFO   = 3'h2;
    localparam logic [2:0]  OP_RD_DISP   = 3'h3;
    localparam logic [2:0]  OP_WR_DISP   = 3'h4;
    localparam logic [2:0]  OP_CLEAR     = 3'h6;
    localparam logic [2:0]  OP_END_INT   = 3'h7;
    localparam int          CMD_AI_BIT   = 4;
    localparam int          CMD_CD_BIT   = 4;
    localparam int          CMD_CF_BIT   = 1;
    localparam int          CMD_CA_BIT   = 0;
    localparam int          CMD_E_BIT    = 4;
    localparam logic [1:0]  DD_RESET     = 2'h1;
    localparam logic [2:0]  KKK_RESET    = 3'h0;
    localparam int          ST_DU_BIT    = 7;
    localparam int          ST_SE_BIT    = 6;
    localparam int          ST_OVR_BIT   = 5;
    localparam int          ST_UND_BIT   = 4;
    localparam int          ST_FULL_BIT  = 3;
    localparam logic [3:0]  FIFO_DEPTH   = 4'h8;
    localparam logic [1:0]  DEB_SCANS    = 2'h2;
endpackage

// ==== kdi_strobe_src.sv ====
// Strobed data source model driving the return lines and the strobe input.
`timescale 1ns/100ps
`default_nettype none
module kdi_strobe_src (
    // Clock, reset and bench request.
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       send,
    input  wire logic [7:0] send_data,
    // Return lines and strobe.
    output logic      [7:0] return_lines,
    output logic            strobe
);
    logic [1:0] phase_reg;
    // Data is held through the strobe rising edge, then inverted to expose stale sampling.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            return_lines <= 8'hff;
            strobe <= 1'b0;
            phase_reg <= 2'h0;
        end else if (send && phase_reg == 2'h0) begin
            return_lines <= send_data;
            phase_reg <= 2'h1;
        end else if (phase_reg == 2'h1) begin
            strobe <= 1'b1;
            phase_reg <= 2'h2;
        end else if (phase_reg == 2'h2) begin
            strobe <= 1'b0;
            return_lines <= ~return_lines;
            phase_reg <= 2'h0;
        end
    end
endmodule
`default_nettype wire

// ==== tb_keyboard_sensor_display_entry.sv ====
// Self-checking testbench for the keyboard, sensor and display entry block.
`timescale 1ns/100ps
`default_nettype none
module tb_keyboard_sensor_display_entry;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [7:0]  rl;
    logic        stb;
    logic        send = 1'b0;
    logic [7:0]  send_data = 8'h00;
    logic [31:0] rd;
    logic        er;
    logic        irq;
    logic [7:0]  dout;
    logic [3:0]  scan;
    int          error_cnt = 0;
    int          cmp_count = 0;
    kdi_entry uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .return_lines(rl), .shift_input(1'b0),
        .control_or_strobe_input(stb), .scan_line_outputs(scan), .display_out(dout), .irq(irq));
    kdi_strobe_src src (.pclk(pclk), .presetn(presetn), .send(send),
        .send_data(send_data), .return_lines(rl), .strobe(stb));
    initial begin
        forever #5 pclk = ~pclk;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rdchk(input logic [11:0] a, input logic [7:0] exp);
        apb(1'b0, a, 8'h00);
        cmp(rd, {24'h0, exp});
    endtask
    task automatic push(input logic [7:0] d);
        @(posedge pclk);
        send_data <= d;
        send <= 1'b1;
        @(posedge pclk);
        send <= 1'b0;
        repeat (4) @(posedge pclk);
    endtask
    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_bus;
        apb(1'b0, 12'h008, 8'h00);
        cmp({31'h0, er}, 32'h1);
        cmp(rd, 32'h0);
        $display("test bus done");
    endtask
    task automatic t_fifo;
        apb(1'b1, kdi_pkg::ADDR_CMD, 8'h0e);
        apb(1'b1, kdi_pkg::ADDR_CMD, 8'hc2);
        for (int i = 0; i < 8; i++) push(8'h10 + 8'(i));
        rdchk(kdi_pkg::ADDR_CMD, 8'h08);
        push(8'h99);
        rdchk(kdi_pkg::ADDR_CMD, 8'h28);
        apb(1'b1, kdi_pkg::ADDR_CMD, 8'h40);
        for (int i = 0; i < 8; i++) rdchk(kdi_pkg::ADDR_DATA, 8'h10 + 8'(i));
        rdchk(kdi_pkg::ADDR_CMD, 8'h20);
        apb(1'b0, kdi_pkg::ADDR_DATA, 8'h00);
        rdchk(kdi_pkg::ADDR_CMD, 8'h30);
        push(8'h5a);
        cmp({31'h0, irq}, 32'h1);
        apb(1'b1, kdi_pkg::ADDR_CMD, 8'hc2);
        rdchk(kdi_pkg::ADDR_CMD, 8'h00);
        cmp({31'h0, irq}, 32'h0);
        $display("test fifo done");
    endtask
    task automatic t_disp;
        apb(1'b1, kdi_pkg::ADDR_CMD, 8'h90);
        for (int i = 0; i < 17; i++) apb(1'b1, kdi_pkg::ADDR_DATA, 8'ha0 + 8'(i));
        apb(1'b1, kdi_pkg::ADDR_CMD, 8'h70);
        cmp({24'h0, dout}, 32'hb0);
        rdchk(kdi_pkg::ADDR_DATA, 8'hb0);
        rdchk(kdi_pkg::ADDR_DATA, 8'ha1);
        apb(1'b1, kdi_pkg::ADDR_CMD, 8'h85);
        apb(1'b1, kdi_pkg::ADDR_DATA, 8'h55);
        apb(1'b1, kdi_pkg::ADDR_DATA, 8'h66);
        apb(1'b1, kdi_pkg::ADDR_CMD, 8'h65);
        rdchk(kdi_pkg::ADDR_DATA, 8'h66);
        rdchk(kdi_pkg::ADDR_DATA, 8'h66);
        // Three right entries shift the shown line left by three places.
        apb(1'b1, kdi_pkg::ADDR_CMD, 8'h1e);
        apb(1'b1, kdi_pkg::ADDR_CMD, 8'h90);
        for (int i = 0; i < 3; i++) apb(1'b1, kdi_pkg::ADDR_DATA, 8'hc0 + 8'(i));
        repeat (2) @(posedge pclk);
        cmp({24'h0, dout}, 32'ha3);
        $display("test display done");
    endtask
    task automatic t_clear;
        apb(1'b1, kdi_pkg::ADDR_CMD, 8'h90);
        apb(1'b1, kdi_pkg::ADDR_CMD, 8'hd0);
        rdchk(kdi_pkg::ADDR_CMD, 8'h80);
        apb(1'b1, kdi_pkg::ADDR_DATA, 8'h77);
        repeat (17000) @(posedge pclk);
        rdchk(kdi_pkg::ADDR_CMD, 8'h00);
        apb(1'b1, kdi_pkg::ADDR_CMD, 8'h70);
        rdchk(kdi_pkg::ADDR_DATA, 8'h00);
        $display("test clear done");
    endtask
    task automatic t_err;
        apb(1'b1, kdi_pkg::ADDR_CMD, 8'h0b);
        apb(1'b1, kdi_pkg::ADDR_CMD, 8'hf0);
        // The source leaves 0xa5 on the returns, so columns 1, 3, 4 and 6 of every row read as pressed.
        push(8'h5a);
        cmp({28'h0, scan}, 32'h1);
        repeat (20000) @(posedge pclk);
        rdchk(kdi_pkg::ADDR_CMD, 8'h40);
        cmp({31'h0, irq}, 32'h1);
        apb(1'b1, kdi_pkg::ADDR_CMD, 8'hc2);
        rdchk(kdi_pkg::ADDR_CMD, 8'h00);
        cmp({31'h0, irq}, 32'h0);
        $display("test error mode done");
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        t_bus();
        t_fifo();
        t_disp();
        t_clear();
        t_err();
        wrap_up();
    end
    initial begin
        repeat (60000) @(posedge pclk);
        error_cnt++;
        wrap_up();
    end
endmodule
`default_nettype wire
